// file: cpld_logic_macrocell.sv
// Summary of operation
// - five product terms over global and regional inputs
// - selector shares terms between sum and controls
// - five-term sum, chain extends to forty
// - xor second input: term, high or low
// - constant-high xor input inverts; emulates T, JK
// - register data from xor, term or pin
// - term data gives buried register, combinational pin
// - D, T, JK, SR modes plus transparent latch
// - clock from three globals or term; rising edge
// - term clock enable low ignores global edges
// - clear from global, term, both, or off
// - preset from term or off only
// - output and feedback each registered or combinational
// - output enable from on, off, pins, term
// - disabled buffer makes pin an input
// - matrix picks forty signals from global bus
// - foldback is inverse of one own term
// - signature readable whatever the fuse state
`timescale 1ns/1ps
`include "macrocell_params.svh"
module cpld_logic_macrocell #(
    parameter int GLOBAL_WIDTH = 128,
    parameter int MATRIX_INPUTS = 40,
    parameter int REGION_WIDTH = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic io_pin_in,
    input wire logic [1:0] oe_pin,
    input wire logic io_enable_pin,
    input wire logic [2:0] global_clock_line,
    input wire logic global_clear_line,
    input wire logic [GLOBAL_WIDTH-1:0] global_bus_in,
    input wire logic [REGION_WIDTH-1:0] regional_bus_in,
    input wire logic chained_sum_input,
    output logic io_pin_out,
    output logic io_pin_oe,
    output logic buried_feedback,
    output logic foldback_out,
    output logic chained_sum_output,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int SEL_W = $clog2(GLOBAL_WIDTH);
    localparam int BLOCK_W = MATRIX_INPUTS + REGION_WIDTH;
    localparam int TERMS = `MC_TERM_COUNT;

    // ****************************************
    // helpers
    // ****************************************
    // picks one term by index; indices past the last term read low
    function automatic logic term_pick(input logic [TERMS-1:0] terms, input logic [2:0] idx);
        term_pick = (idx < 3'(TERMS)) ? terms[idx] : 1'b0;
    endfunction

    function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        merge_word = res;
    endfunction

    function automatic logic is_term(input logic [11:0] addr);
        is_term = addr >= `MC_TERM_BASE && addr < `MC_TERM_END && addr[1:0] == 2'h0;
    endfunction

    function automatic logic is_sel(input logic [11:0] addr);
        is_sel = addr >= `MC_SEL_BASE && addr < `MC_SEL_END && addr[1:0] == 2'h0;
    endfunction

    function automatic logic is_known(input logic [11:0] addr);
        is_known = addr == `MC_ADDR_CFG0 || addr == `MC_ADDR_CFG1 || addr == `MC_ADDR_SIG
            || addr == `MC_ADDR_FUSE || addr == `MC_ADDR_STATUS || is_term(addr) || is_sel(addr);
    endfunction

    // ****************************************
    // configuration storage
    // ****************************************
    macrocell_pkg::cfg0_type cfg0;
    macrocell_pkg::cfg1_type cfg1;
    logic [15:0] signature;
    logic fuse;
    logic [63:0] term_true [TERMS];
    logic [63:0] term_comp [TERMS];
    logic [SEL_W-1:0] matrix_sel [MATRIX_INPUTS];

    // ****************************************
    // pin synchroniser
    // ****************************************
    macrocell_pkg::pin_type pin_raw;
    macrocell_pkg::pin_type pin_meta;
    macrocell_pkg::pin_type pin_sync;
    assign pin_raw = '{io_pin: io_pin_in, oe_pin: oe_pin, io_enable_pin: io_enable_pin,
                       gclk: global_clock_line, gclr: global_clear_line};

    // two stages; only the second stage feeds logic
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // ****************************************
    // switch matrix and product terms
    // ****************************************
    logic [MATRIX_INPUTS-1:0] matrix_out;
    logic [BLOCK_W-1:0] block_in;
    logic [TERMS-1:0] pt;

    // each matrix output is one global bus line chosen by software; the regional bus fills the upper block inputs
    for (genvar i = 0; i < MATRIX_INPUTS; i++) begin : g_matrix
        assign matrix_out[i] = (32'(matrix_sel[i]) < GLOBAL_WIDTH) ?
            global_bus_in[matrix_sel[i]] : 1'b0;
    end
    assign block_in = {regional_bus_in, matrix_out};

    // a term with no literals enabled reads high, as an unprogrammed AND would
    for (genvar t = 0; t < TERMS; t++) begin : g_terms
        assign pt[t] = &(~term_true[t][BLOCK_W-1:0] | block_in)
            & &(~term_comp[t][BLOCK_W-1:0] | ~block_in);
    end

    // ****************************************
    // sum, polarity and data selection
    // ****************************************
    logic or_sum;
    logic xor_second;
    logic xor_out;
    logic data_in;
    logic k_in;
    logic fold_val;
    assign or_sum = |(pt & cfg0.sum_mask) | (cfg0.chain_en & chained_sum_input);
    assign xor_second = (cfg0.xor_sel == macrocell_pkg::XOR_HIGH) ? 1'b1 :
        (cfg0.xor_sel == macrocell_pkg::XOR_TERM) ? term_pick(pt, cfg0.xor_term) : 1'b0;
    assign xor_out = or_sum ^ xor_second;
    assign data_in = (cfg0.data_sel == macrocell_pkg::DATA_TERM) ? term_pick(pt, cfg0.data_term) :
        (cfg0.data_sel == macrocell_pkg::DATA_PIN) ? pin_sync.io_pin : xor_out;
    assign k_in = term_pick(pt, cfg1.k_term);
    assign fold_val = term_pick(pt, cfg1.fold_term);

    // ****************************************
    // clock, enable, clear and preset
    // ****************************************
    logic clk_level;
    logic clk_prev;
    logic rise;
    logic ce_used;
    logic ce_val;
    logic edge_taken;
    logic clear_act;
    logic set_act;
    logic q;
    logic next_q;
    // the selected clock is sampled; an edge is seen as low then high
    assign clk_level = (cfg0.clk_sel == macrocell_pkg::CLK_TERM) ?
        term_pick(pt, cfg0.clk_term) : pin_sync.gclk[cfg0.clk_sel];
    assign rise = clk_level & ~clk_prev;
    assign ce_used = cfg0.ce_en & (cfg0.clk_sel != macrocell_pkg::CLK_TERM);
    assign ce_val = term_pick(pt, cfg0.ce_term);
    assign edge_taken = rise & (~ce_used | ce_val);
    assign clear_act = ((cfg1.clr_sel == macrocell_pkg::CLR_GLOBAL
        || cfg1.clr_sel == macrocell_pkg::CLR_BOTH) & pin_sync.gclr)
        | ((cfg1.clr_sel == macrocell_pkg::CLR_TERM || cfg1.clr_sel == macrocell_pkg::CLR_BOTH)
        & term_pick(pt, cfg1.clr_term));
    // global clear never reaches the preset path
    assign set_act = cfg1.set_en & term_pick(pt, cfg1.set_term);

    // storage update; clear is checked first so it beats preset
    always_comb begin
        next_q = q;
        if (clear_act) begin
            next_q = 1'b0;
        end else if (set_act) begin
            next_q = 1'b1;
        end else if (cfg0.mode == macrocell_pkg::MODE_LATCH) begin
            next_q = clk_level ? data_in : q;
        end else if (edge_taken) begin
            case (cfg0.mode)
                macrocell_pkg::MODE_D: next_q = data_in;
                macrocell_pkg::MODE_T: next_q = q ^ data_in;
                macrocell_pkg::MODE_JK: next_q = (data_in & ~q) | (~k_in & q);
                macrocell_pkg::MODE_SR: next_q = data_in | (~k_in & q);
                default: next_q = q;
            endcase
        end
    end

    // ****************************************
    // output and enable selection
    // ****************************************
    logic next_oe;
    assign next_oe = (cfg1.oe_sel == macrocell_pkg::OE_ON) ? 1'b1 :
        (cfg1.oe_sel == macrocell_pkg::OE_PIN0) ? pin_sync.oe_pin[0] :
        (cfg1.oe_sel == macrocell_pkg::OE_PIN1) ? pin_sync.oe_pin[1] :
        (cfg1.oe_sel == macrocell_pkg::OE_IO_PIN) ? pin_sync.io_enable_pin :
        (cfg1.oe_sel == macrocell_pkg::OE_TERM) ? term_pick(pt, cfg1.oe_term) : 1'b0;

    // every cell output is a flop so a neighbour sees a clean level
    always_ff @(posedge clock) begin
        if (reset) begin
            q <= 1'b0;
            clk_prev <= 1'b0;
            io_pin_out <= 1'b0;
            io_pin_oe <= 1'b0;
            buried_feedback <= 1'b0;
            foldback_out <= 1'b1;
            chained_sum_output <= 1'b0;
        end else begin
            q <= next_q;
            clk_prev <= clk_level;
            io_pin_out <= cfg0.out_reg ? next_q : xor_out;
            io_pin_oe <= next_oe;
            buried_feedback <= cfg0.fb_reg ? next_q : xor_out;
            foldback_out <= ~fold_val;
            chained_sum_output <= or_sum;
        end
    end

    // ****************************************
    // register bus
    // ****************************************
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_do;
    logic [2:0] wr_term_idx;
    logic [5:0] wr_sel_idx;
    logic [31:0] read_value;
    logic [2:0] rd_term_idx;
    logic [5:0] rd_sel_idx;
    logic [63:0] rd_term_mask;
    // both halves held and no answer pending means the write can land
    assign wr_do = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    assign wr_term_idx = 3'((wr_addr - `MC_TERM_BASE) >> `MC_TERM_SHIFT);
    assign wr_sel_idx = 6'((wr_addr - `MC_SEL_BASE) >> `MC_WORD_SHIFT);
    assign rd_term_idx = 3'((s_axi_araddr - `MC_TERM_BASE) >> `MC_TERM_SHIFT);
    assign rd_sel_idx = 6'((s_axi_araddr - `MC_SEL_BASE) >> `MC_WORD_SHIFT);
    assign rd_term_mask = s_axi_araddr[3] ? term_comp[rd_term_idx] : term_true[rd_term_idx];

    // a programmed fuse hides the pattern, but the signature stays visible
    always_comb begin
        read_value = 32'h00000000;
        if (s_axi_araddr == `MC_ADDR_SIG) begin
            read_value = {16'h0000, signature};
        end else if (s_axi_araddr == `MC_ADDR_FUSE) begin
            read_value = {31'h00000000, fuse};
        end else if (s_axi_araddr == `MC_ADDR_STATUS) begin
            read_value = {28'h0000000, io_pin_oe, pin_sync.io_pin, or_sum, q};
        end else if (!fuse) begin
            if (s_axi_araddr == `MC_ADDR_CFG0) begin
                read_value = cfg0;
            end else if (s_axi_araddr == `MC_ADDR_CFG1) begin
                read_value = cfg1;
            end else if (is_term(s_axi_araddr)) begin
                read_value = s_axi_araddr[2] ? rd_term_mask[63:32] : rd_term_mask[31:0];
            end else if (is_sel(s_axi_araddr)) begin
                read_value = 32'(matrix_sel[rd_sel_idx]);
            end
        end
    end

    // write channel: each half is held until both are in, then answered
    always_ff @(posedge clock) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MC_RESP_OKAY;
            wr_addr <= 12'h000;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_known(wr_addr) ? `MC_RESP_OKAY : `MC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // register file writes; the fuse only ever sets until reset
    always_ff @(posedge clock) begin
        if (reset) begin
            cfg0 <= macrocell_pkg::cfg0_type'(`MC_CFG_RESET);
            cfg1 <= macrocell_pkg::cfg1_type'(`MC_CFG_RESET);
            signature <= `MC_SIG_RESET;
            fuse <= 1'b0;
            for (int t = 0; t < TERMS; t++) begin
                term_true[t] <= {2{`MC_CFG_RESET}};
                term_comp[t] <= {2{`MC_CFG_RESET}};
            end
            for (int i = 0; i < MATRIX_INPUTS; i++) begin
                matrix_sel[i] <= '0;
            end
        end else if (wr_do) begin
            if (wr_addr == `MC_ADDR_CFG0) begin
                cfg0 <= macrocell_pkg::cfg0_type'(merge_word(cfg0, wr_data, wr_strb));
            end
            if (wr_addr == `MC_ADDR_CFG1) begin
                cfg1 <= macrocell_pkg::cfg1_type'(merge_word(cfg1, wr_data, wr_strb));
            end
            if (wr_addr == `MC_ADDR_SIG) begin
                signature <= 16'(merge_word({16'h0000, signature}, wr_data, wr_strb));
            end
            if (wr_addr == `MC_ADDR_FUSE && wr_strb[0] && wr_data[0]) begin
                fuse <= 1'b1;
            end
            if (is_term(wr_addr)) begin
                case (wr_addr[3:2])
                    2'h0: term_true[wr_term_idx][31:0] <=
                        merge_word(term_true[wr_term_idx][31:0], wr_data, wr_strb);
                    2'h1: term_true[wr_term_idx][63:32] <=
                        merge_word(term_true[wr_term_idx][63:32], wr_data, wr_strb);
                    2'h2: term_comp[wr_term_idx][31:0] <=
                        merge_word(term_comp[wr_term_idx][31:0], wr_data, wr_strb);
                    default: term_comp[wr_term_idx][63:32] <=
                        merge_word(term_comp[wr_term_idx][63:32], wr_data, wr_strb);
                endcase
            end
            if (is_sel(wr_addr)) begin
                matrix_sel[wr_sel_idx] <= SEL_W'(merge_word(32'(matrix_sel[wr_sel_idx]),
                    wr_data, wr_strb));
            end
        end
    end

    // read channel: data is captured as the address is taken
    always_ff @(posedge clock) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= read_value;
                s_axi_rresp <= is_known(s_axi_araddr) ? `MC_RESP_OKAY : `MC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    AST_CLEAR_WINS: assert property (@(posedge clock) disable iff (reset)
        clear_act && set_act |=> !q) else $error("preset beat clear");
    AST_GLOBAL_CLEAR: assert property (@(posedge clock) disable iff (reset)
        (cfg1.clr_sel == macrocell_pkg::CLR_GLOBAL || cfg1.clr_sel == macrocell_pkg::CLR_BOTH)
        && pin_sync.gclr |=> !q) else $error("global clear did not clear");
    AST_PRESET: assert property (@(posedge clock) disable iff (reset)
        set_act && !clear_act |=> q) else $error("preset did not set");
    AST_CE_BLOCKS: assert property (@(posedge clock) disable iff (reset)
        ce_used && !ce_val && cfg0.mode != macrocell_pkg::MODE_LATCH && !clear_act && !set_act
        |=> $stable(q)) else $error("disabled edge changed state");
    AST_NO_EDGE: assert property (@(posedge clock) disable iff (reset)
        !rise && cfg0.mode != macrocell_pkg::MODE_LATCH && !clear_act && !set_act
        |=> $stable(q)) else $error("state changed without rising edge");
    AST_LATCH: assert property (@(posedge clock) disable iff (reset)
        cfg0.mode == macrocell_pkg::MODE_LATCH && clk_level && !clear_act && !set_act
        |=> q == $past(data_in)) else $error("latch not transparent");
    AST_PIN_INPUT: assert property (@(posedge clock) disable iff (reset)
        cfg1.oe_sel == macrocell_pkg::OE_OFF |=> !io_pin_oe) else $error("disabled buffer drives");
    AST_FOLDBACK: assert property (@(posedge clock) disable iff (reset)
        !reset |=> foldback_out == !$past(fold_val)) else $error("foldback not inverse of term");
    AST_COMB_OUT: assert property (@(posedge clock) disable iff (reset)
        !cfg0.out_reg |=> io_pin_out == $past(xor_out)) else $error("combinational output wrong");
    AST_CHAIN: assert property (@(posedge clock) disable iff (reset)
        cfg0.chain_en && chained_sum_input |=> chained_sum_output) else $error("chain input lost");
    AST_SIG_READ: assert property (@(posedge clock) disable iff (reset)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `MC_ADDR_SIG
        |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(signature)) else $error("signature hidden");
endmodule

// file: far_side_model.sv
`timescale 1ns/1ps
// ****************************************
// board side of the cell's pin
// ****************************************
module far_side_model (
    input wire logic io_pin_out,
    input wire logic io_pin_oe,
    input wire logic ext_level,
    output logic io_pin_in
);
    // the cell owns the wire while it drives; otherwise the board level shows
    // no keeper here, so a released pin never echoes the cell's old value
    assign io_pin_in = io_pin_oe ? io_pin_out : ext_level;
endmodule

// file: macrocell_params.svh
`ifndef MACROCELL_PARAMS_SVH
`define MACROCELL_PARAMS_SVH
// ****************************************
// register map
// ****************************************
`define MC_ADDR_CFG0 12'h000
`define MC_ADDR_CFG1 12'h004
`define MC_ADDR_SIG 12'h008
`define MC_ADDR_FUSE 12'h00C
`define MC_ADDR_STATUS 12'h010
`define MC_TERM_BASE 12'h080
`define MC_TERM_END 12'h0D0
`define MC_SEL_BASE 12'h100
`define MC_SEL_END 12'h1A0
// ****************************************
// sizes, reset values, answers
// ****************************************
`define MC_TERM_COUNT 5
`define MC_TERM_SHIFT 4
`define MC_WORD_SHIFT 2
`define MC_CFG_RESET 32'h00000000
`define MC_SIG_RESET 16'h0000
`define MC_RESP_OKAY 2'h0
`define MC_RESP_SLVERR 2'h2
`endif

// file: macrocell_pkg.sv
package macrocell_pkg;
    typedef enum logic [1:0] {XOR_LOW, XOR_HIGH, XOR_TERM} xor_sel_type;
    typedef enum logic [1:0] {DATA_XOR, DATA_TERM, DATA_PIN} data_sel_type;
    typedef enum logic [2:0] {MODE_D, MODE_T, MODE_JK, MODE_SR, MODE_LATCH} storage_mode_type;
    typedef enum logic [1:0] {CLK_GLOBAL0, CLK_GLOBAL1, CLK_GLOBAL2, CLK_TERM} clk_sel_type;
    typedef enum logic [1:0] {CLR_OFF, CLR_GLOBAL, CLR_TERM, CLR_BOTH} clear_sel_type;
    typedef enum logic [2:0] {OE_OFF, OE_ON, OE_PIN0, OE_PIN1, OE_IO_PIN, OE_TERM} oe_sel_type;

    // first configuration word
    typedef struct packed {
        logic [1:0] reserved;
        logic fb_reg;
        logic out_reg;
        logic [2:0] ce_term;
        logic ce_en;
        logic [2:0] clk_term;
        clk_sel_type clk_sel;
        storage_mode_type mode;
        logic [2:0] data_term;
        data_sel_type data_sel;
        logic [2:0] xor_term;
        xor_sel_type xor_sel;
        logic chain_en;
        logic [4:0] sum_mask;
    } cfg0_type;

    // second configuration word
    typedef struct packed {
        logic [10:0] reserved;
        logic [2:0] k_term;
        logic [2:0] fold_term;
        logic [2:0] oe_term;
        oe_sel_type oe_sel;
        logic [2:0] set_term;
        logic set_en;
        logic [2:0] clr_term;
        clear_sel_type clr_sel;
    } cfg1_type;

    // pin levels that cross into the clock domain
    typedef struct packed {
        logic io_pin;
        logic [1:0] oe_pin;
        logic io_enable_pin;
        logic [2:0] gclk;
        logic gclr;
    } pin_type;
endpackage

// file: tb_cpld_logic_macrocell.sv
`timescale 1ns/1ps
`include "macrocell_params.svh"
module tb_cpld_logic_macrocell;
// ****************************************
// stimulus, partner and dut
// ****************************************
logic clock = 1'h0;
logic reset = 1'h1;
logic io_pin_in, io_pin_out, io_pin_oe, buried_feedback, foldback_out, chained_sum_output;
logic [1:0] oe_pin = 2'h0;
logic io_enable_pin = 1'h0;
logic [2:0] global_clock_line = 3'h0;
logic global_clear_line = 1'h0;
logic [127:0] global_bus_in = 128'h0;
logic [15:0] regional_bus_in = 16'h0000;
logic chained_sum_input = 1'h0;
logic ext_level = 1'h0;
logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
logic [31:0] s_axi_wdata = 32'h00000000;
logic [3:0] s_axi_wstrb = 4'hF;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic [1:0] s_axi_bresp, s_axi_rresp, resp;
logic [31:0] s_axi_rdata, got;
int miscompares = 0;
int comparisons = 0;
always #4 clock = ~clock;
far_side_model pins (.io_pin_out, .io_pin_oe, .ext_level, .io_pin_in);
cpld_logic_macrocell dut (.clock, .reset, .io_pin_in, .oe_pin, .io_enable_pin,
    .global_clock_line, .global_clear_line, .global_bus_in, .regional_bus_in,
    .chained_sum_input, .io_pin_out, .io_pin_oe, .buried_feedback,
    .foldback_out, .chained_sum_output, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
// ****************************************
// bus and check tasks
// ****************************************
// address and data offered together, each dropped at its own take
task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
        @(posedge clock);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
endtask
// data and response are taken at the handshake edge itself
task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
        @(posedge clock);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
endtask
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
        miscompares++;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
endtask
task automatic bit_chk(input logic g, input logic e);
    chk({31'h00000000, g}, {31'h00000000, e});
endtask
task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
endtask
// pins need two synchroniser edges plus the output flop, so allow five
task automatic see_out(input logic e);
    wait_n(5);
    bit_chk(io_pin_out, e);
endtask
// one slow edge on global line 0, long enough to pass the synchroniser
task automatic pulse;
    @(posedge clock) global_clock_line <= 3'h1;
    wait_n(5);
    global_clock_line <= 3'h0;
    wait_n(5);
endtask
task automatic summarize;
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
// ****************************************
// tests
// ****************************************
initial begin
    wait_n(2);
    reset <= 1'h0;
    rd(`MC_ADDR_CFG0, got, resp);
    chk(got, `MC_CFG_RESET);
    rd(12'h020, got, resp);
    chk({30'h0, resp}, {30'h0, `MC_RESP_SLVERR});
    // term0 on regional bit 0, term1 on regional bit 1, buffer on
    wr(`MC_TERM_BASE + 12'h004, 32'h00000100);
    wr(`MC_TERM_BASE + 12'h014, 32'h00000200);
    wr(`MC_ADDR_CFG1, 32'h00000200);
    wr(`MC_ADDR_CFG0, 32'h00000001);
    @(posedge clock) regional_bus_in <= 16'h0001;
    see_out(1'h1);
    bit_chk(buried_feedback, 1'h1);
    bit_chk(io_pin_oe, 1'h1);
    bit_chk(foldback_out, 1'h0);
    wr(`MC_ADDR_CFG0, 32'h00000041);
    see_out(1'h0);
    // sum made only of the neighbour's chain
    wr(`MC_ADDR_CFG0, 32'h00000020);
    @(posedge clock) chained_sum_input <= 1'h1;
    see_out(1'h1);
    bit_chk(chained_sum_output, 1'h1);
    @(posedge clock) chained_sum_input <= 1'h0;
    see_out(1'h0);
    bit_chk(chained_sum_output, 1'h0);
    // registered D on global line 0: nothing moves before the edge
    wr(`MC_ADDR_CFG0, 32'h10000001);
    see_out(1'h0);
    pulse();
    see_out(1'h1);
    // enable from term1: low ignores the edge, high lets it through
    wr(`MC_ADDR_CFG0, 32'h13000001);
    @(posedge clock) regional_bus_in <= 16'h0000;
    pulse();
    see_out(1'h1);
    bit_chk(foldback_out, 1'h1);
    @(posedge clock) regional_bus_in <= 16'h0002;
    pulse();
    see_out(1'h0);
    wr(`MC_ADDR_CFG0, 32'h10000001);
    @(posedge clock) regional_bus_in <= 16'h0001;
    pulse();
    see_out(1'h1);
    // global clear, then preset from term0 fighting it
    wr(`MC_ADDR_CFG1, 32'h00000201);
    @(posedge clock) global_clear_line <= 1'h1;
    see_out(1'h0);
    wr(`MC_ADDR_CFG1, 32'h00000221);
    see_out(1'h0);
    @(posedge clock) global_clear_line <= 1'h0;
    see_out(1'h1);
    // buffer enable from dedicated pin 0
    wr(`MC_ADDR_CFG1, 32'h00000400);
    @(posedge clock) oe_pin <= 2'h1;
    wait_n(5);
    bit_chk(io_pin_oe, 1'h1);
    @(posedge clock) oe_pin <= 2'h0;
    wait_n(5);
    bit_chk(io_pin_oe, 1'h0);
    bit_chk(buried_feedback, 1'h1);
    // register data straight from the released pin, held low by the board
    wr(`MC_ADDR_CFG0, 32'h10001001);
    pulse();
    see_out(1'h0);
    // toggle mode fed by the xor: each taken edge flips the state
    wr(`MC_ADDR_CFG0, 32'h10010001);
    pulse();
    see_out(1'h1);
    pulse();
    see_out(1'h0);
    // latch follows data while its clock is high, holds once it is low
    wr(`MC_ADDR_CFG0, 32'h10040001);
    @(posedge clock) global_clock_line <= 3'h1;
    see_out(1'h1);
    @(posedge clock) global_clock_line <= 3'h0;
    wait_n(5);
    @(posedge clock) regional_bus_in <= 16'h0000;
    see_out(1'h1);
    // block input 0 picks global line 5, term2 uses it alone
    wr(`MC_SEL_BASE, 32'h00000005);
    wr(`MC_TERM_BASE + 12'h020, 32'h00000001);
    wr(`MC_ADDR_CFG0, 32'h00000004);
    @(posedge clock) global_bus_in <= 128'h20;
    see_out(1'h1);
    @(posedge clock) global_bus_in <= 128'h0;
    see_out(1'h0);
    // signature stays readable once configuration is hidden
    wr(`MC_ADDR_SIG, 32'h0000A5C3);
    wr(`MC_ADDR_FUSE, 32'h00000001);
    rd(`MC_ADDR_SIG, got, resp);
    chk(got, 32'h0000A5C3);
    rd(`MC_ADDR_CFG0, got, resp);
    chk(got, 32'h00000000);
    summarize();
end
// whole run is a few hundred cycles; this is far beyond it
initial begin
    #100000;
    miscompares++;
    summarize();
end
endmodule
